// File: include/fb_status_pkg.sv
// constants for the fieldbus status word and reference/actual codecs
// assumes a single system clock domain around every user of it
package fb_status_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int STAT_W = 32;
   localparam int FB_W = 16;
   localparam int VAL_W = 32;
   localparam int TYPE_W = 2;
   localparam int SHIFT_W = 5;
   localparam int NUM_CH = 2;
   localparam int USER_W = 4;
   // ---------------------------------------------------------------
   // status bit positions
   // ---------------------------------------------------------------
   localparam int BIT_READY = 0;
   localparam int BIT_RUN_ENABLE = 1;
   localparam int BIT_MODULATING = 3;
   localparam int BIT_ZERO_SPEED = 4;
   localparam int BIT_TARGET = 7;
   localparam int BIT_LIMIT = 8;
   localparam int BIT_SUPERVISION = 9;
   localparam int BIT_PANEL_LOCAL = 12;
   localparam int BIT_BUS_LOCAL = 13;
   localparam int BIT_SECOND_SRC = 14;
   localparam int BIT_FAULT = 15;
   localparam int BIT_WARNING = 16;
   localparam int BIT_USER_LO = 22;
   localparam int BIT_CTL_REQ = 26;
   localparam int FB_SIGN = 15;
   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] IMPL_MASK = 32'h07C1_F39B;
   localparam logic [15:0] FB_RESET = 16'h0000;
   localparam logic [31:0] VAL_RESET = 32'h0000_0000;
   // ---------------------------------------------------------------
   // scaling: type setting to shift count
   // ---------------------------------------------------------------
   localparam logic [1:0] TYPE_UNITY = 2'h0;
   localparam logic [1:0] TYPE_X2 = 2'h1;
   localparam logic [1:0] TYPE_X4 = 2'h2;
   localparam logic [1:0] TYPE_X16 = 2'h3;
   localparam logic [4:0] SHIFT_UNITY = 5'h00;
   localparam logic [4:0] SHIFT_X2 = 5'h01;
   localparam logic [4:0] SHIFT_X4 = 5'h02;
   localparam logic [4:0] SHIFT_X16 = 5'h04;
   // ---------------------------------------------------------------
   // 16-bit two's complement limits
   // ---------------------------------------------------------------
   localparam logic signed [31:0] FB_MAX_VAL = 32'sh0000_7FFF;
   localparam logic signed [31:0] FB_MIN_VAL = 32'shFFFF_8000;
   localparam logic [15:0] FB_MAX_WORD = 16'h7FFF;
   localparam logic [15:0] FB_MIN_WORD = 16'h8000;
endpackage

// File: include/scale_if.sv
// one reference/actual channel between the encoder and its scaler
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface scale_if;
   logic [15:0] ref_word;
   logic [1:0] ref_type;
   logic signed [31:0] ref_value;
   logic signed [31:0] act_value;
   logic [1:0] act_type;
   logic [15:0] act_word;
   logic act_clipped;
   modport ctrl (
      output ref_word, ref_type, act_value, act_type,
      input ref_value, act_word, act_clipped
   );
   modport conv (
      input ref_word, ref_type, act_value, act_type,
      output ref_value, act_word, act_clipped
   );
endinterface

// File: logic/word_scaler.sv
// combinational scaler for one reference and one actual value
// assumes the caller registers every result
`timescale 1ns/1ps
module word_scaler (
   // channel
   scale_if.conv lane
);
   // ---------------------------------------------------------------
   // type to shift lookup
   // ---------------------------------------------------------------
   function automatic logic [4:0] type_shift(input logic [1:0] t);
      case (t)
         fb_status_pkg::TYPE_UNITY: type_shift = fb_status_pkg::SHIFT_UNITY;
         fb_status_pkg::TYPE_X2: type_shift = fb_status_pkg::SHIFT_X2;
         fb_status_pkg::TYPE_X4: type_shift = fb_status_pkg::SHIFT_X4;
         default: type_shift = fb_status_pkg::SHIFT_X16;
      endcase
   endfunction

   logic signed [31:0] ref_wide;
   logic signed [31:0] act_shifted;

   // ---------------------------------------------------------------
   // conversion
   // ---------------------------------------------------------------
   always_comb begin
      // sign bit replicated: master sends negatives as two's complement
      ref_wide = {{16{lane.ref_word[fb_status_pkg::FB_SIGN]}},
                  lane.ref_word};
      lane.ref_value = ref_wide <<< type_shift(lane.ref_type);
      act_shifted = lane.act_value >>> type_shift(lane.act_type);
      lane.act_clipped = 1'b0;
      // clip to the signed 16-bit range, keeping two's complement
      if (act_shifted > fb_status_pkg::FB_MAX_VAL) begin
         lane.act_word = fb_status_pkg::FB_MAX_WORD;
         lane.act_clipped = 1'b1;
      end else if (act_shifted < fb_status_pkg::FB_MIN_VAL) begin
         lane.act_word = fb_status_pkg::FB_MIN_WORD;
         lane.act_clipped = 1'b1;
      end else begin
         lane.act_word = act_shifted[15:0];
      end
   end
endmodule

// File: logic/fieldbus_status_ref_encoder.sv
// fieldbus status word assembly and reference/actual value codec
// assumes all flag inputs come from logic on clk; no pins enter here
//
// Summary of operation
// - low sixteen status bits go out unchanged
// - bit 0 set when start can be accepted
// - bit 1 follows external run permission
// - bit 3 set while power stage modulates
// - bit 4 set at zero speed
// - bit 7 set when setpoint reached
// - bit 8 set while any limitation active
// - bit 9 set when supervised value exceeds threshold
// - bit 12 set under keypad or tool control
// - bit 13 set under fieldbus local control
// - bit 14 set when second source active
// - bit 15 fault, bit 16 warning
// - bits 22 to 25 are user flags
// - bit 26 set when channel control requested
// - two references, 16-bit two's complement, sign extended
// - two actual values, sign plus 15 bits
// - negative actuals sent as two's complement
// - each reference scaled by own type setting
// - each actual scaled by own type setting
`timescale 1ns/1ps
module fieldbus_status_ref_encoder (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // drive state flags
   input wire logic ready_to_start,
   input wire logic run_permission,
   input wire logic modulating_flag,
   input wire logic zero_speed,
   input wire logic target_reached_flag,
   input wire logic limit_active,
   input wire logic supervision_exceeded,
   input wire logic panel_local,
   input wire logic bus_local,
   input wire logic second_external_source_flag,
   input wire logic fault_active,
   input wire logic warning_active,
   input wire logic [3:0] user_flags,
   input wire logic channel_control_requested,
   // status outputs
   output logic [31:0] drive_state_flags_alt_profile,
   output logic [15:0] fb_status_word,
   output logic status_changed,
   // references from the bus master
   input wire logic [1:0][15:0] ref_word_in,
   input wire logic [1:0] ref_write,
   input wire logic [1:0][1:0] ref_type,
   output logic [1:0][31:0] ref_value,
   output logic [1:0] ref_update,
   // actual values to the bus master
   input wire logic [1:0][31:0] feedback_value_in,
   input wire logic [1:0][1:0] act_type,
   output logic [1:0][15:0] act_word,
   output logic [1:0] act_clipped
);
   // ---------------------------------------------------------------
   // status assembly
   // ---------------------------------------------------------------
   function automatic logic [31:0] build_status(
      input logic rdy, input logic run_en, input logic modul,
      input logic zspd, input logic tgt, input logic lim,
      input logic sup, input logic pnl, input logic bus,
      input logic ext2, input logic flt, input logic wrn,
      input logic [3:0] usr, input logic req
   );
      logic [31:0] s;
      s = fb_status_pkg::STATUS_RESET;
      s[fb_status_pkg::BIT_READY] = rdy;
      s[fb_status_pkg::BIT_RUN_ENABLE] = run_en;
      s[fb_status_pkg::BIT_MODULATING] = modul;
      s[fb_status_pkg::BIT_ZERO_SPEED] = zspd;
      s[fb_status_pkg::BIT_TARGET] = tgt;
      s[fb_status_pkg::BIT_LIMIT] = lim;
      s[fb_status_pkg::BIT_SUPERVISION] = sup;
      s[fb_status_pkg::BIT_PANEL_LOCAL] = pnl;
      s[fb_status_pkg::BIT_BUS_LOCAL] = bus;
      s[fb_status_pkg::BIT_SECOND_SRC] = ext2;
      s[fb_status_pkg::BIT_FAULT] = flt;
      s[fb_status_pkg::BIT_WARNING] = wrn;
      s[fb_status_pkg::BIT_USER_LO +: fb_status_pkg::USER_W] = usr;
      s[fb_status_pkg::BIT_CTL_REQ] = req;
      build_status = s & fb_status_pkg::IMPL_MASK;
   endfunction

   logic [31:0] next_status;
   logic [15:0] next_fb;
   logic next_changed;

   always_comb begin
      next_status = build_status(ready_to_start, run_permission,
         modulating_flag, zero_speed, target_reached_flag,
         limit_active, supervision_exceeded, panel_local, bus_local,
         second_external_source_flag, fault_active, warning_active,
         user_flags, channel_control_requested);
      // upper half never enters the 16-bit transfer
      next_fb = next_status[15:0];
      next_changed = next_status != drive_state_flags_alt_profile;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         drive_state_flags_alt_profile <= fb_status_pkg::STATUS_RESET;
         fb_status_word <= fb_status_pkg::FB_RESET;
         status_changed <= 1'b0;
      end else if (ce) begin
         drive_state_flags_alt_profile <= next_status;
         fb_status_word <= next_fb;
         status_changed <= next_changed;
      end
   end

   // ---------------------------------------------------------------
   // reference and actual channels
   // ---------------------------------------------------------------
   scale_if lane [fb_status_pkg::NUM_CH] ();

   logic [1:0][15:0] ref_hold;
   logic [1:0][15:0] next_ref_hold;
   logic [1:0] ref_pending;
   logic [1:0] next_ref_pending;
   logic [1:0][31:0] next_ref_value;
   logic [1:0][15:0] next_act_word;
   logic [1:0] next_act_clipped;

   genvar g;
   generate
      for (g = 0; g < fb_status_pkg::NUM_CH; g++) begin : ch
         word_scaler u_scaler (
            .lane(lane[g])
         );
         assign lane[g].ref_word = ref_hold[g];
         assign lane[g].ref_type = ref_type[g];
         assign lane[g].act_value = feedback_value_in[g];
         assign lane[g].act_type = act_type[g];
         always_comb begin
            // word held until the master writes a new one
            next_ref_hold[g] = ref_write[g] ? ref_word_in[g]
                                            : ref_hold[g];
            next_ref_pending[g] = ref_write[g];
            next_ref_value[g] = lane[g].ref_value;
            next_act_word[g] = lane[g].act_word;
            next_act_clipped[g] = lane[g].act_clipped;
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         ref_hold <= '0;
         ref_pending <= '0;
         ref_value <= '0;
         ref_update <= '0;
         act_word <= '0;
         act_clipped <= '0;
      end else if (ce) begin
         ref_hold <= next_ref_hold;
         ref_pending <= next_ref_pending;
         ref_value <= next_ref_value;
         ref_update <= ref_pending;
         act_word <= next_act_word;
         act_clipped <= next_act_clipped;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   fb_low_copy_a: assert property (
      @(posedge clk) disable iff (rst)
      fb_status_word == drive_state_flags_alt_profile[15:0])
      else $error("fieldbus word differs from low status half");

   reserved_zero_a: assert property (
      @(posedge clk) disable iff (rst)
      (drive_state_flags_alt_profile & ~fb_status_pkg::IMPL_MASK) == '0)
      else $error("reserved status bit set");

   ready_bit_a: assert property (
      @(posedge clk) disable iff (rst)
      ce ##1 1'b1 |-> drive_state_flags_alt_profile[0]
         == $past(ready_to_start))
      else $error("ready bit does not follow start readiness");

   run_perm_a: assert property (
      @(posedge clk) disable iff (rst)
      ce && run_permission |=> drive_state_flags_alt_profile[1])
      else $error("run permission bit not set");

   motion_bits_a: assert property (
      @(posedge clk) disable iff (rst)
      ce |=> drive_state_flags_alt_profile[3] == $past(modulating_flag)
         && drive_state_flags_alt_profile[4] == $past(zero_speed))
      else $error("modulation or zero speed bit wrong");

   fault_warn_a: assert property (
      @(posedge clk) disable iff (rst)
      ce && fault_active && warning_active
         |=> drive_state_flags_alt_profile[16:15] == 2'h3)
      else $error("fault or warning bit missing");

   user_field_a: assert property (
      @(posedge clk) disable iff (rst)
      ce |=> drive_state_flags_alt_profile[25:22] == $past(user_flags))
      else $error("user flags misplaced");

   ctl_req_a: assert property (
      @(posedge clk) disable iff (rst)
      ce |=> drive_state_flags_alt_profile[26]
         == $past(channel_control_requested))
      else $error("control request bit wrong");

   frozen_state_a: assert property (
      @(posedge clk) disable iff (rst)
      !ce |=> $stable(drive_state_flags_alt_profile) && $stable(act_word))
      else $error("state moved while clock enable low");

   ref_sign_a: assert property (
      @(posedge clk) disable iff (rst)
      ce && ref_write[0] && ref_type[0] == fb_status_pkg::TYPE_UNITY
         ##1 ce && ref_type[0] == fb_status_pkg::TYPE_UNITY
         |=> ref_update[0] && ref_value[0][31:15]
            == {17{$past(ref_hold[0][15])}})
      else $error("reference sign not extended");

   act_neg_a: assert property (
      @(posedge clk) disable iff (rst)
      ce && feedback_value_in[1][31] |=> act_word[1][15])
      else $error("negative actual lost its sign");

   act_unity_a: assert property (
      @(posedge clk) disable iff (rst)
      ce && act_type[0] == fb_status_pkg::TYPE_UNITY
         |=> act_clipped[0]
            || act_word[0] == $past(feedback_value_in[0][15:0]))
      else $error("unity actual not passed through");

   act_clip_a: assert property (
      @(posedge clk) disable iff (rst)
      act_clipped[0] |-> act_word[0] == fb_status_pkg::FB_MAX_WORD
         || act_word[0] == fb_status_pkg::FB_MIN_WORD)
      else $error("clipped actual not at a range limit");
endmodule

// File: sim/bus_master_model.sv
// fieldbus master model: sends the two reference words
// assumes the bench holds a send request for one clock
`timescale 1ns/1ps
module bus_master_model (
   // clock
   input wire logic clk,
   // request from the bench
   input wire logic send,
   input wire logic send_ch,
   input wire logic [14:0] send_mag,
   input wire logic send_neg,
   // reference side of the drive
   output logic [1:0][15:0] ref_word_in,
   output logic [1:0] ref_write
);
   initial begin
      ref_word_in = '0;
      ref_write = '0;
   end
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (send && send_ch == i[0]) begin
            ref_word_in[i] <= send_neg ? 16'h0000 - {1'b0, send_mag}
               : {1'b0, send_mag};
            ref_write[i] <= 1'b1;
         end else begin
            // word is stale once the strobe is gone
            ref_word_in[i] <= ~ref_word_in[i];
            ref_write[i] <= 1'b0;
         end
      end
   end
endmodule

// File: sim/fieldbus_status_ref_encoder_test.sv
// self-checking bench for the status word and value codecs
// assumes bus_master_model drives the reference words
`timescale 1ns/1ps
module fieldbus_status_ref_encoder_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [16:0] fl = '0;
   logic [1:0][1:0] ref_type = '0;
   logic [1:0][1:0] act_type = '0;
   logic [1:0][31:0] fbv = '0;
   logic send = 1'b0;
   logic send_ch = 1'b0;
   logic [14:0] send_mag = '0;
   logic send_neg = 1'b0;
   logic [31:0] status;
   logic [15:0] fbw;
   logic chg;
   logic [1:0][15:0] ref_word_in;
   logic [1:0] ref_write;
   logic [1:0][31:0] ref_value;
   logic [1:0] ref_update;
   logic [1:0][15:0] act_word;
   logic [1:0] act_clipped;
   logic [31:0] last = '0;
   int mismatches = 0;
   int n_checks = 0;
   int pos[17] = '{0, 1, 3, 4, 7, 8, 9, 12, 13, 14, 15, 16, 26,
      22, 23, 24, 25};
   logic [31:0] av[8] = '{32'hFFFF_FFFB, 32'h0000_7FFF, 32'h0000_8000,
      32'hFFFF_8000, 32'hFFFF_7FFF, 32'h0000_FFFE, 32'h0008_0000,
      32'hFFFF_FFD0};
   logic [1:0] at[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
   always #5 clk = ~clk;
   fieldbus_status_ref_encoder DUT (
      .clk(clk), .rst(rst), .ce(ce),
      .ready_to_start(fl[0]), .run_permission(fl[1]),
      .modulating_flag(fl[2]), .zero_speed(fl[3]),
      .target_reached_flag(fl[4]), .limit_active(fl[5]),
      .supervision_exceeded(fl[6]), .panel_local(fl[7]),
      .bus_local(fl[8]), .second_external_source_flag(fl[9]),
      .fault_active(fl[10]), .warning_active(fl[11]),
      .channel_control_requested(fl[12]), .user_flags(fl[16:13]),
      .drive_state_flags_alt_profile(status), .fb_status_word(fbw),
      .status_changed(chg), .ref_word_in(ref_word_in),
      .ref_write(ref_write), .ref_type(ref_type),
      .ref_value(ref_value), .ref_update(ref_update),
      .feedback_value_in(fbv), .act_type(act_type),
      .act_word(act_word), .act_clipped(act_clipped)
   );
   bus_master_model master (
      .clk(clk), .send(send), .send_ch(send_ch), .send_mag(send_mag),
      .send_neg(send_neg), .ref_word_in(ref_word_in),
      .ref_write(ref_write)
   );
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic int shf(logic [1:0] t);
      case (t)
         fb_status_pkg::TYPE_X2: return fb_status_pkg::SHIFT_X2;
         fb_status_pkg::TYPE_X4: return fb_status_pkg::SHIFT_X4;
         fb_status_pkg::TYPE_X16: return fb_status_pkg::SHIFT_X16;
         default: return fb_status_pkg::SHIFT_UNITY;
      endcase
   endfunction
   function automatic logic [16:0] exp_act(logic [31:0] v, logic [1:0] t);
      logic signed [31:0] s;
      s = $signed(v) >>> shf(t);
      if (s > fb_status_pkg::FB_MAX_VAL) return {1'b1, 16'h7FFF};
      if (s < fb_status_pkg::FB_MIN_VAL) return {1'b1, 16'h8000};
      return {1'b0, s[15:0]};
   endfunction
   task automatic put_flags(logic [16:0] f);
      logic [31:0] e;
      e = '0;
      for (int i = 0; i < 17; i++) if (f[i]) e[pos[i]] = 1'b1;
      fl = f;
      tick(1);
      check("st", status, e);
      check("fb", fbw, e[15:0]);
      check("chg", chg, e != last);
      check("rsv", status & ~e, 32'h0);
      last = e;
   endtask
   task automatic do_ref(logic ch, logic [14:0] mag, logic neg,
      logic [1:0] t);
      int v;
      int k;
      ref_type[ch] = t;
      send = 1'b1;
      send_ch = ch;
      send_mag = mag;
      send_neg = neg;
      tick(1);
      send = 1'b0;
      k = 0;
      while (ref_update[ch] !== 1'b1 && k < 10) begin
         tick(1);
         k++;
      end
      v = neg ? -int'(mag) : int'(mag);
      check("ref", ref_value[ch], v <<< shf(t));
      check("upd", k < 10, 1'b1);
      check("upd_other", ref_update[~ch], 1'b0);
      tick(1);
      check("upd_end", ref_update[ch], 1'b0);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
   initial begin
      tick(2);
      rst = 1'b0;
      check("rst_st", status, 32'h0);
      check("rst_act", act_word, 32'h0);
      for (int i = 0; i < 17; i++) put_flags(17'h1 << i);
      put_flags('1);
      put_flags('1);
      ce = 1'b0;
      fl = '0;
      tick(2);
      check("hold", status, last);
      check("hold_fb", fbw, last[15:0]);
      ce = 1'b1;
      put_flags('0);
      do_ref(1'b0, 15'h0005, 1'b1, 2'h0);
      do_ref(1'b1, 15'h7FFF, 1'b0, 2'h3);
      do_ref(1'b0, 15'h7FFF, 1'b1, 2'h1);
      do_ref(1'b1, 15'h0000, 1'b1, 2'h2);
      do_ref(1'b1, 15'h0002, 1'b1, 2'h2);
      do_ref(1'b0, 15'h0003, 1'b0, 2'h0);
      ref_type[0] = 2'h3;
      tick(2);
      check("retype", ref_value[0], 32'h0000_0030);
      check("other", ref_value[1], 32'hFFFF_FFF8);
      for (int i = 0; i < 8; i++) begin
         fbv[0] = av[i];
         fbv[1] = av[7 - i];
         act_type[0] = at[i];
         act_type[1] = at[7 - i];
         tick(1);
         for (int c = 0; c < 2; c++) begin
            check("act", {act_clipped[c], act_word[c]},
               exp_act(fbv[c], act_type[c]));
         end
      end
      fl = '1;
      rst = 1'b1;
      tick(1);
      check("rst_mid", status, 32'h0);
      check("rst_mid_act", act_word, 32'h0);
      rst = 1'b0;
      last = '0;
      put_flags('1);
      stop_test();
   end
endmodule
